// ==== rtl/ictm_consts.svh ====
// constants for the instruction cycle timing model
`ifndef ICTM_CONSTS_SVH
`define ICTM_CONSTS_SVH

// table entry layout: best, cache, worst clocks, then reads, worst-case prefetches, writes
`define ICTM_E_W 36
`define ICTM_F_BEST 35:28
`define ICTM_F_CACHE 27:20
`define ICTM_F_WORST 19:12
`define ICTM_F_RD 11:8
`define ICTM_F_PF 7:4
`define ICTM_F_WR 3:0

// widths of counts
`define ICTM_N_W 5
`define ICTM_TOT_W 10
`define ICTM_CLK_W 8
`define ICTM_CNT_W 5

// per-register steps of the multiple-register forms
`define ICTM_LOAD_STEP 3'h4
`define ICTM_STORE_STEP 3'h3

// timing entries
`define ICTM_E_XCHG 36'h00_02_03_010
`define ICTM_E_CTRL_TO_REG 36'h03_06_07_010
`define ICTM_E_REG_TO_CTRL 36'h09_0C_0D_010
`define ICTM_E_STWORD_TO_REG 36'h01_04_05_010
`define ICTM_E_STWORD_TO_MEM 36'h05_05_07_011
`define ICTM_E_EA_TO_CCB 36'h04_04_05_010
`define ICTM_E_EA_TO_STAT 36'h08_08_0B_020
`define ICTM_E_MULTI_LOAD 36'h08_08_09_010
`define ICTM_E_MULTI_STORE 36'h04_04_05_010
`define ICTM_E_PERIPH_W_TO_MEM 36'h08_0B_0B_012
`define ICTM_E_PERIPH_L_TO_MEM 36'h0E_11_11_014
`define ICTM_E_PERIPH_W_TO_REG 36'h0A_0C_0C_210
`define ICTM_E_PERIPH_L_TO_REG 36'h10_12_12_410
`define ICTM_E_ALT_TO_REG 36'h07_07_08_110
`define ICTM_E_ALT_FROM_REG 36'h05_05_07_011
`define ICTM_E_USTACK_MOVE 36'h00_02_03_010
`define ICTM_E_HALF_SWAP 36'h01_04_04_010
`define ICTM_E_ALU_REG 36'h00_02_03_010
`define ICTM_E_ALU_MEM 36'h03_04_06_011
`define ICTM_E_ADDR_CMP 36'h01_04_04_010
`define ICTM_E_BOUNDS_CMP 36'h10_12_12_110
`define ICTM_E_MULT_W 36'h19_1B_1C_010
`define ICTM_E_MULT_L 36'h29_2B_2C_010
`define ICTM_E_UDIV_W 36'h2A_2C_2C_010
`define ICTM_E_UDIV_L 36'h4C_4E_4F_010
`define ICTM_E_SDIV_W 36'h36_38_39_010
`define ICTM_E_SDIV_L 36'h58_5A_5B_010
`define ICTM_E_IMM_REG 36'h00_02_03_010
`define ICTM_E_IMM_MEM 36'h03_04_06_011

`endif

// ==== rtl/ictm_pkg.sv ====
// types of the instruction cycle timing model
package ictm_pkg;

	// instruction forms that the model can time
	typedef enum logic [4:0] {
		ICTM_OP_XCHG, ICTM_OP_CTRL_TO_REG, ICTM_OP_REG_TO_CTRL, ICTM_OP_STWORD_TO_REG,
		ICTM_OP_STWORD_TO_MEM, ICTM_OP_EA_TO_CCB, ICTM_OP_EA_TO_STAT, ICTM_OP_MULTI_LOAD,
		ICTM_OP_MULTI_STORE, ICTM_OP_PERIPH_W_TO_MEM, ICTM_OP_PERIPH_L_TO_MEM,
		ICTM_OP_PERIPH_W_TO_REG, ICTM_OP_PERIPH_L_TO_REG, ICTM_OP_ALT_TO_REG,
		ICTM_OP_ALT_FROM_REG, ICTM_OP_USTACK_MOVE, ICTM_OP_HALF_SWAP, ICTM_OP_ALU_REG,
		ICTM_OP_ALU_MEM, ICTM_OP_ADDR_CMP, ICTM_OP_BOUNDS_CMP, ICTM_OP_MULT_W, ICTM_OP_MULT_L,
		ICTM_OP_UDIV_W, ICTM_OP_UDIV_L, ICTM_OP_SDIV_W, ICTM_OP_SDIV_L, ICTM_OP_QUICK_REG,
		ICTM_OP_QUICK_MEM, ICTM_OP_IMM_REG, ICTM_OP_IMM_MEM
	} ictm_op_t;

	// timing column
	typedef enum logic [1:0] {
		ICTM_COL_BEST, ICTM_COL_CACHE, ICTM_COL_WORST
	} ictm_col_t;

	// separately tabulated time that a form needs on top of its total
	typedef enum logic [2:0] {
		ICTM_ADD_NONE, ICTM_ADD_FETCH_EA, ICTM_ADD_CALC_EA, ICTM_ADD_CALC_IMM, ICTM_ADD_FETCH_IMM
	} ictm_addon_t;

	// sequencer states of the top
	typedef enum logic [1:0] {
		ICTM_S_IDLE, ICTM_S_CALC, ICTM_S_LAUNCH, ICTM_S_RUN
	} ictm_state_t;

endpackage : ictm_pkg

// ==== rtl/ictm_core_if.sv ====
// carrier between the timing top, the total calculator and the bus sequencer
`timescale 1ns/100ps
`include "ictm_consts.svh"

interface ictm_core_if;
	logic load;
	logic [`ICTM_CLK_W-1:0] base;
	logic [2:0] step;
	logic [`ICTM_N_W-1:0] n;
	logic addon_en;
	logic [`ICTM_CLK_W-1:0] addon;
	logic [`ICTM_TOT_W-1:0] total;
	logic go;
	logic [`ICTM_CNT_W-1:0] reads;
	logic [`ICTM_CNT_W-1:0] prefs;
	logic [`ICTM_CNT_W-1:0] writes;
	logic busy;
	logic done;
	logic bus_rd;
	logic bus_pf;
	logic bus_wr;

	modport main (output load, base, step, n, addon_en, addon, go, reads, prefs, writes,
		input total, busy, done, bus_rd, bus_pf, bus_wr);
	modport calc (input load, base, step, n, addon_en, addon, output total);
	modport seq (input go, total, reads, prefs, writes, output busy, done, bus_rd, bus_pf, bus_wr);
endinterface : ictm_core_if

// ==== rtl/ictm_total_calc.sv ====
// total clock count: column base plus per-register term plus add-on time
`timescale 1ns/100ps
`include "ictm_consts.svh"

module ictm_total_calc (
	input wire logic clk_i,
	input wire logic rst_i,
	ictm_core_if.calc core
);
	import ictm_pkg::*;

	logic [`ICTM_TOT_W-1:0] total_q;
	logic [`ICTM_TOT_W-1:0] total_d;

	////////////////////////////////////////////////////////////////////////
	// per-register term
	always_comb begin
		total_d = total_q;
		if (core.load) begin
			total_d = `ICTM_TOT_W'(core.base) + `ICTM_TOT_W'(core.step) * `ICTM_TOT_W'(core.n);
			if (core.addon_en) begin
				total_d = total_d + `ICTM_TOT_W'(core.addon);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			total_q <= '0;
		end else begin
			total_q <= total_d;
		end
	end

	assign core.total = total_q;

endmodule : ictm_total_calc

// ==== rtl/ictm_bus_seq.sv ====
// runs one timed instruction and places its bus cycles inside the total
`timescale 1ns/100ps
`include "ictm_consts.svh"

module ictm_bus_seq (
	input wire logic clk_i,
	input wire logic rst_i,
	ictm_core_if.seq core
);
	import ictm_pkg::*;

	logic active_q, active_d;
	logic [`ICTM_TOT_W-1:0] rem_q, rem_d;
	logic [`ICTM_CNT_W-1:0] rd_q, rd_d;
	logic [`ICTM_CNT_W-1:0] pf_q, pf_d;
	logic [`ICTM_CNT_W-1:0] wr_q, wr_d;
	logic ticking;

	////////////////////////////////////////////////////////////////////////
	// one bus cycle per clock: reads, then writes, prefetch of the next last
	assign ticking = active_q && (rem_q != '0);
	assign core.bus_rd = ticking && (rd_q != '0);
	assign core.bus_wr = ticking && (rd_q == '0) && (wr_q != '0);
	assign core.bus_pf = ticking && (rd_q == '0) && (wr_q == '0) && (pf_q != '0);
	assign core.busy = ticking;
	assign core.done = active_q && (rem_q == '0);

	// bus cycles counted inside the total, never added
	always_comb begin
		active_d = active_q;
		rem_d = rem_q;
		rd_d = rd_q;
		pf_d = pf_q;
		wr_d = wr_q;
		if (core.go) begin
			active_d = 1'b1;
			rem_d = core.total;
			rd_d = core.reads;
			pf_d = core.prefs;
			wr_d = core.writes;
		end else if (core.done) begin
			active_d = 1'b0;
		end else if (ticking) begin
			rem_d = rem_q - `ICTM_TOT_W'(1);
			if (core.bus_rd) begin
				rd_d = rd_q - `ICTM_CNT_W'(1);
			end
			if (core.bus_wr) begin
				wr_d = wr_q - `ICTM_CNT_W'(1);
			end
			if (core.bus_pf) begin
				pf_d = pf_q - `ICTM_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q <= 1'b0;
			rem_q <= '0;
			rd_q <= '0;
			pf_q <= '0;
			wr_q <= '0;
		end else begin
			active_q <= active_d;
			rem_q <= rem_d;
			rd_q <= rd_d;
			pf_q <= pf_d;
			wr_q <= wr_d;
		end
	end

endmodule : ictm_bus_seq

// ==== rtl/ictm_timing.sv ====
// top of the instruction cycle timing model: lookup, column choice and run control
// Notes on behaviour
// - bus cycles are part of the total
// - worst arithmetic case holds one prefetch
// - register exchange takes 0/2/3 clocks
// - control register alternate_space_move take 3/6/7, 9/12/13
// - status register 8/8/11, condition byte 4/4/5
// - status word store: memory 5/5/7, register 1/4/5
// - multi-register load 8+4n, worst 9+4n
// - multi-register store 4+3n, worst 5+3n
// - peripheral stores: 2 or 4 writes
// - peripheral loads: 2 or 4 reads
// - alternate space alternate_space_move 7/7/8 and 5/5/7
// - stack pointer 0/2/3, half swap 1/4/4
// - ALU to register 0/2/3, memory 3/4/6
// - address compare 1/4/4, bounds 16/18/18
// - multiply word 25/27/28, long 41/43/44
// - unsigned divide 42/44/44 and 76/78/79
// - signed divide 54/56/57 and 88/90/91
// - immediate ops register 0/2/3, memory 3/4/6
// - add tabulated address time when flagged
`timescale 1ns/100ps
`include "ictm_consts.svh"

module ictm_timing (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input ictm_pkg::ictm_op_t op_i,
	input wire logic cache_hit_i,
	input wire logic overlap_i,
	input wire logic [`ICTM_N_W-1:0] reg_count_i,
	input wire logic [`ICTM_CLK_W-1:0] addon_time_i,
	output logic ready_o,
	output logic busy_o,
	output logic done_o,
	output ictm_pkg::ictm_col_t column_o,
	output ictm_pkg::ictm_addon_t addon_kind_o,
	output logic [`ICTM_TOT_W-1:0] total_o,
	output logic [`ICTM_CNT_W-1:0] reads_o,
	output logic [`ICTM_CNT_W-1:0] prefetches_o,
	output logic [`ICTM_CNT_W-1:0] writes_o,
	output logic bus_read_o,
	output logic bus_prefetch_o,
	output logic bus_write_o
);
	import ictm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// lookup of one instruction form
	function automatic logic [`ICTM_E_W-1:0] entry_of(input ictm_op_t op);
		logic [`ICTM_E_W-1:0] e;
		e = `ICTM_E_ALU_REG;
		case (op)
			ICTM_OP_XCHG: e = `ICTM_E_XCHG;
			ICTM_OP_CTRL_TO_REG: e = `ICTM_E_CTRL_TO_REG;
			ICTM_OP_REG_TO_CTRL: e = `ICTM_E_REG_TO_CTRL;
			ICTM_OP_STWORD_TO_REG: e = `ICTM_E_STWORD_TO_REG;
			ICTM_OP_STWORD_TO_MEM: e = `ICTM_E_STWORD_TO_MEM;
			ICTM_OP_EA_TO_CCB: e = `ICTM_E_EA_TO_CCB;
			ICTM_OP_EA_TO_STAT: e = `ICTM_E_EA_TO_STAT;
			ICTM_OP_MULTI_LOAD: e = `ICTM_E_MULTI_LOAD;
			ICTM_OP_MULTI_STORE: e = `ICTM_E_MULTI_STORE;
			ICTM_OP_PERIPH_W_TO_MEM: e = `ICTM_E_PERIPH_W_TO_MEM;
			ICTM_OP_PERIPH_L_TO_MEM: e = `ICTM_E_PERIPH_L_TO_MEM;
			ICTM_OP_PERIPH_W_TO_REG: e = `ICTM_E_PERIPH_W_TO_REG;
			ICTM_OP_PERIPH_L_TO_REG: e = `ICTM_E_PERIPH_L_TO_REG;
			ICTM_OP_ALT_TO_REG: e = `ICTM_E_ALT_TO_REG;
			ICTM_OP_ALT_FROM_REG: e = `ICTM_E_ALT_FROM_REG;
			ICTM_OP_USTACK_MOVE: e = `ICTM_E_USTACK_MOVE;
			ICTM_OP_HALF_SWAP: e = `ICTM_E_HALF_SWAP;
			ICTM_OP_ALU_REG: e = `ICTM_E_ALU_REG;
			ICTM_OP_ALU_MEM: e = `ICTM_E_ALU_MEM;
			ICTM_OP_ADDR_CMP: e = `ICTM_E_ADDR_CMP;
			ICTM_OP_BOUNDS_CMP: e = `ICTM_E_BOUNDS_CMP;
			ICTM_OP_MULT_W: e = `ICTM_E_MULT_W;
			ICTM_OP_MULT_L: e = `ICTM_E_MULT_L;
			ICTM_OP_UDIV_W: e = `ICTM_E_UDIV_W;
			ICTM_OP_UDIV_L: e = `ICTM_E_UDIV_L;
			ICTM_OP_SDIV_W: e = `ICTM_E_SDIV_W;
			ICTM_OP_SDIV_L: e = `ICTM_E_SDIV_L;
			ICTM_OP_QUICK_REG: e = `ICTM_E_IMM_REG;
			ICTM_OP_QUICK_MEM: e = `ICTM_E_IMM_MEM;
			ICTM_OP_IMM_REG: e = `ICTM_E_IMM_REG;
			ICTM_OP_IMM_MEM: e = `ICTM_E_IMM_MEM;
			default: e = `ICTM_E_ALU_REG;
		endcase
		return e;
	endfunction : entry_of

	// which tabulated time a form still needs on top of its total
	function automatic ictm_addon_t addon_of(input ictm_op_t op);
		ictm_addon_t k;
		k = ICTM_ADD_NONE;
		case (op)
			ICTM_OP_STWORD_TO_MEM: k = ICTM_ADD_CALC_EA;
			ICTM_OP_EA_TO_CCB, ICTM_OP_EA_TO_STAT, ICTM_OP_ALU_REG, ICTM_OP_ALU_MEM,
			ICTM_OP_ADDR_CMP, ICTM_OP_MULT_W, ICTM_OP_UDIV_W, ICTM_OP_SDIV_W,
			ICTM_OP_QUICK_MEM: k = ICTM_ADD_FETCH_EA;
			ICTM_OP_MULTI_LOAD, ICTM_OP_MULTI_STORE, ICTM_OP_ALT_TO_REG,
			ICTM_OP_ALT_FROM_REG: k = ICTM_ADD_CALC_IMM;
			ICTM_OP_BOUNDS_CMP, ICTM_OP_MULT_L, ICTM_OP_UDIV_L, ICTM_OP_SDIV_L,
			ICTM_OP_IMM_REG, ICTM_OP_IMM_MEM: k = ICTM_ADD_FETCH_IMM;
			default: k = ICTM_ADD_NONE;
		endcase
		return k;
	endfunction : addon_of

	// hit with overlap is best, hit alone is cache, a miss is worst
	function automatic ictm_col_t col_of(input logic hit, input logic ovl);
		ictm_col_t c;
		if (!hit) begin
			c = ICTM_COL_WORST;
		end else if (ovl) begin
			c = ICTM_COL_BEST;
		end else begin
			c = ICTM_COL_CACHE;
		end
		return c;
	endfunction : col_of

	// column pick of the base clock count
	function automatic logic [`ICTM_CLK_W-1:0] base_of(input logic [`ICTM_E_W-1:0] e, input ictm_col_t c);
		logic [`ICTM_CLK_W-1:0] b;
		case (c)
			ICTM_COL_BEST: b = e[`ICTM_F_BEST];
			ICTM_COL_CACHE: b = e[`ICTM_F_CACHE];
			default: b = e[`ICTM_F_WORST];
		endcase
		return b;
	endfunction : base_of

	////////////////////////////////////////////////////////////////////////
	// request capture and sequencing state
	ictm_state_t state_q, state_d;
	ictm_op_t op_q, op_d;
	ictm_col_t col_q, col_d;
	logic [`ICTM_N_W-1:0] n_q, n_d;
	logic [`ICTM_CLK_W-1:0] addon_q, addon_d;

	// result registers shown at the outputs
	logic [`ICTM_TOT_W-1:0] total_q, total_d;
	logic [`ICTM_CNT_W-1:0] rd_q, rd_d;
	logic [`ICTM_CNT_W-1:0] pf_q, pf_d;
	logic [`ICTM_CNT_W-1:0] wr_q, wr_d;
	ictm_addon_t kind_q, kind_d;

	logic [`ICTM_E_W-1:0] ent;
	ictm_addon_t kind_now;
	logic [`ICTM_CNT_W-1:0] rd_now;
	logic [`ICTM_CNT_W-1:0] pf_now;
	logic [`ICTM_CNT_W-1:0] wr_now;

	ictm_core_if core ();

	////////////////////////////////////////////////////////////////////////
	// per-form figures from the captured request
	assign ent = entry_of(op_q);
	assign kind_now = addon_of(op_q);

	// prefetch of the next instruction only in the worst column
	assign pf_now = (col_q == ICTM_COL_WORST) ? `ICTM_CNT_W'(ent[`ICTM_F_PF]) : '0;

	always_comb begin
		rd_now = `ICTM_CNT_W'(ent[`ICTM_F_RD]);
		wr_now = `ICTM_CNT_W'(ent[`ICTM_F_WR]);
		if (op_q == ICTM_OP_MULTI_LOAD) begin
			rd_now = `ICTM_CNT_W'(n_q);
		end
		if (op_q == ICTM_OP_MULTI_STORE) begin
			wr_now = `ICTM_CNT_W'(n_q);
		end
	end

	// drive of the calculator, step is zero except for register lists
	assign core.load = (state_q == ICTM_S_CALC);
	assign core.base = base_of(ent, col_q);
	assign core.n = n_q;
	assign core.addon = addon_q;
	assign core.addon_en = (kind_now != ICTM_ADD_NONE);
	always_comb begin
		core.step = 3'h0;
		if (op_q == ICTM_OP_MULTI_LOAD) begin
			core.step = `ICTM_LOAD_STEP;
		end else if (op_q == ICTM_OP_MULTI_STORE) begin
			core.step = `ICTM_STORE_STEP;
		end
	end

	// launch of the bus sequencer with the fresh total
	assign core.go = (state_q == ICTM_S_LAUNCH);
	assign core.reads = rd_q;
	assign core.prefs = pf_q;
	assign core.writes = wr_q;

	////////////////////////////////////////////////////////////////////////
	// control: a start while not idle is dropped, the caller watches ready_o
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		col_d = col_q;
		n_d = n_q;
		addon_d = addon_q;
		total_d = total_q;
		rd_d = rd_q;
		pf_d = pf_q;
		wr_d = wr_q;
		kind_d = kind_q;
		case (state_q)
			ICTM_S_IDLE: begin
				if (start_i) begin
					op_d = op_i;
					col_d = col_of(cache_hit_i, overlap_i);
					n_d = reg_count_i;
					addon_d = addon_time_i;
					state_d = ICTM_S_CALC;
				end
			end
			ICTM_S_CALC: begin
				rd_d = rd_now;
				pf_d = pf_now;
				wr_d = wr_now;
				kind_d = kind_now;
				state_d = ICTM_S_LAUNCH;
			end
			ICTM_S_LAUNCH: begin
				total_d = core.total;
				state_d = ICTM_S_RUN;
			end
			ICTM_S_RUN: begin
				if (core.done) begin
					state_d = ICTM_S_IDLE;
				end
			end
			default: state_d = ICTM_S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ICTM_S_IDLE;
			op_q <= ICTM_OP_XCHG;
			col_q <= ICTM_COL_WORST;
			n_q <= '0;
			addon_q <= '0;
			total_q <= '0;
			rd_q <= '0;
			pf_q <= '0;
			wr_q <= '0;
			kind_q <= ICTM_ADD_NONE;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			col_q <= col_d;
			n_q <= n_d;
			addon_q <= addon_d;
			total_q <= total_d;
			rd_q <= rd_d;
			pf_q <= pf_d;
			wr_q <= wr_d;
			kind_q <= kind_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the two helpers
	ictm_total_calc u_calc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.core(core.calc)
	);

	ictm_bus_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.core(core.seq)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs; strobes are one clock each, taken from sequencer state
	assign ready_o = (state_q == ICTM_S_IDLE);
	assign busy_o = core.busy;
	assign done_o = (state_q == ICTM_S_RUN) && core.done;
	assign column_o = col_q;
	assign addon_kind_o = kind_q;
	assign total_o = total_q;
	assign reads_o = rd_q;
	assign prefetches_o = pf_q;
	assign writes_o = wr_q;
	assign bus_read_o = core.bus_rd;
	assign bus_prefetch_o = core.bus_pf;
	assign bus_write_o = core.bus_wr;

endmodule : ictm_timing

// ==== verification/ictm_timing_sva.sv ====
// checker of the timing model top ports
`timescale 1ns/100ps
`include "ictm_consts.svh"

module ictm_timing_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input ictm_pkg::ictm_op_t op_i,
	input wire logic cache_hit_i,
	input wire logic overlap_i,
	input wire logic [`ICTM_N_W-1:0] reg_count_i,
	input wire logic [`ICTM_CLK_W-1:0] addon_time_i,
	input wire logic ready_o,
	input wire logic busy_o,
	input wire logic done_o,
	input ictm_pkg::ictm_col_t column_o,
	input ictm_pkg::ictm_addon_t addon_kind_o,
	input wire logic [`ICTM_TOT_W-1:0] total_o,
	input wire logic [`ICTM_CNT_W-1:0] reads_o,
	input wire logic [`ICTM_CNT_W-1:0] prefetches_o,
	input wire logic [`ICTM_CNT_W-1:0] writes_o,
	input wire logic bus_read_o,
	input wire logic bus_prefetch_o,
	input wire logic bus_write_o
);
	import ictm_pkg::*;
	logic [`ICTM_TOT_W-1:0] busy_cnt_q, busy_cnt_d;
	logic [`ICTM_CNT_W-1:0] rd_q, rd_d, pf_q, pf_d, wr_q, wr_d;
	////////////////////////////////////////////////////////////////////////////////
	// per-run tallies, cleared at done so each run starts from zero
	always_comb begin
		busy_cnt_d = done_o ? 10'h000 : busy_cnt_q + 10'(busy_o);
		rd_d = done_o ? 5'h00 : rd_q + 5'(bus_read_o);
		pf_d = done_o ? 5'h00 : pf_q + 5'(bus_prefetch_o);
		wr_d = done_o ? 5'h00 : wr_q + 5'(bus_write_o);
	end
	// tallies registered; reset wipes a run cut short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_cnt_q <= 10'h000;
			rd_q <= 5'h00;
			pf_q <= 5'h00;
			wr_q <= 5'h00;
		end else begin
			busy_cnt_q <= busy_cnt_d;
			rd_q <= rd_d;
			pf_q <= pf_d;
			wr_q <= wr_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_busy_total: assert property (done_o |-> busy_cnt_q == total_o)
		else $error("busy length differs from total");
	chk_bus_counts: assert property (done_o |-> rd_q == reads_o && pf_q == prefetches_o && wr_q == writes_o)
		else $error("strobe tally differs from counts");
	chk_strobe_inside: assert property ((bus_read_o || bus_prefetch_o || bus_write_o)
		|-> busy_o && $onehot0({bus_read_o, bus_prefetch_o, bus_write_o}))
		else $error("strobe outside run or doubled");
	chk_done_end: assert property ($fell(busy_o) && !$past(rst_i) |-> done_o)
		else $error("busy fell without done");
	chk_pref_worst: assert property (bus_prefetch_o |-> column_o == ICTM_COL_WORST)
		else $error("prefetch outside worst column");
	chk_pref_count: assert property (done_o |-> ((column_o == ICTM_COL_WORST) ?
		(prefetches_o inside {5'h01, 5'h02}) : (prefetches_o == 5'h00)))
		else $error("prefetch count wrong for column");
	chk_col_miss: assert property (start_i && ready_o && !cache_hit_i |-> ##2 column_o == ICTM_COL_WORST)
		else $error("miss did not select worst");
	chk_col_hit: assert property (start_i && ready_o && cache_hit_i
		|-> ##2 column_o == ($past(overlap_i, 2) ? ICTM_COL_BEST : ICTM_COL_CACHE))
		else $error("hit selected wrong column");
	chk_load_total: assert property (start_i && ready_o && !cache_hit_i && op_i == ICTM_OP_MULTI_LOAD
		|-> ##3 total_o == 10'h009 + {$past(reg_count_i, 3), 2'b00} + 10'($past(addon_time_i, 3)))
		else $error("multi load worst total wrong");
	chk_store_total: assert property (start_i && ready_o && !cache_hit_i && op_i == ICTM_OP_MULTI_STORE
		|-> ##3 total_o == 10'h005 + 10'h003 * 10'($past(reg_count_i, 3)) + 10'($past(addon_time_i, 3)))
		else $error("multi store worst total wrong");
	chk_accept_hold: assert property (start_i && ready_o |=> !ready_o [*2])
		else $error("ready during setup");
	chk_done_pulse: assert property (done_o |=> !done_o && ready_o && !busy_o)
		else $error("done not a single pulse");
endmodule : ictm_timing_sva

// ==== verification/ictm_mem_model.sv ====
// memory bus partner: counts the bus cycles of one run
`timescale 1ns/100ps

module ictm_mem_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic rd_i,
	input wire logic pf_i,
	input wire logic wr_i,
	output logic [7:0] rd_n_o,
	output logic [7:0] pf_n_o,
	output logic [7:0] wr_n_o
);
	// every strobe is one serviced cycle; the core has no wait input, so none are inserted
	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			rd_n_o <= 8'h00;
			pf_n_o <= 8'h00;
			wr_n_o <= 8'h00;
		end else begin
			rd_n_o <= rd_n_o + 8'(rd_i);
			pf_n_o <= pf_n_o + 8'(pf_i);
			wr_n_o <= wr_n_o + 8'(wr_i);
		end
	end
endmodule : ictm_mem_model

// ==== verification/ictm_timing_tb.sv ====
// self-checking bench of the timing model
`timescale 1ns/100ps
`include "ictm_consts.svh"

module ictm_timing_tb;
	import ictm_pkg::*;
	typedef int ictm_row_t [6];
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic start_i = 1'b0;
	ictm_op_t op_i = ICTM_OP_XCHG;
	logic cache_hit_i = 1'b0;
	logic overlap_i = 1'b0;
	logic [`ICTM_N_W-1:0] reg_count_i = 5'h00;
	logic [`ICTM_CLK_W-1:0] addon_time_i = 8'h00;
	logic clr = 1'b0;
	logic ready_o, busy_o, done_o, bus_read_o, bus_prefetch_o, bus_write_o;
	ictm_col_t column_o;
	ictm_addon_t addon_kind_o;
	logic [`ICTM_TOT_W-1:0] total_o;
	logic [`ICTM_CNT_W-1:0] reads_o, prefetches_o, writes_o;
	logic [7:0] rd_n, pf_n, wr_n;
	int err_total = 0;
	int compares = 0;
	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	ictm_timing u_ictm_timing (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
		.cache_hit_i(cache_hit_i), .overlap_i(overlap_i), .reg_count_i(reg_count_i),
		.addon_time_i(addon_time_i), .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o),
		.column_o(column_o), .addon_kind_o(addon_kind_o), .total_o(total_o), .reads_o(reads_o),
		.prefetches_o(prefetches_o), .writes_o(writes_o), .bus_read_o(bus_read_o),
		.bus_prefetch_o(bus_prefetch_o), .bus_write_o(bus_write_o));
	ictm_mem_model u_ictm_mem_model (.clk_i(clk_i), .clr_i(clr), .rd_i(bus_read_o), .pf_i(bus_prefetch_o),
		.wr_i(bus_write_o), .rd_n_o(rd_n), .pf_n_o(pf_n), .wr_n_o(wr_n));
	////////////////////////////////////////////////////////////////////////////////
	// compare and tally
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", name, exp, seen);
		end
	endtask : check
	// verdict and end of run
	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	// best, cache, worst, reads, writes, add-on kind; plain 0/2/3 forms fall to default
	function automatic ictm_row_t row(input ictm_op_t op);
		case (op)
			ICTM_OP_CTRL_TO_REG: row = '{3, 6, 7, 0, 0, 0};
			ICTM_OP_REG_TO_CTRL: row = '{9, 12, 13, 0, 0, 0};
			ICTM_OP_STWORD_TO_REG: row = '{1, 4, 5, 0, 0, 0};
			ICTM_OP_STWORD_TO_MEM: row = '{5, 5, 7, 0, 1, 2};
			ICTM_OP_EA_TO_CCB: row = '{4, 4, 5, 0, 0, 1};
			ICTM_OP_EA_TO_STAT: row = '{8, 8, 11, 0, 0, 1};
			ICTM_OP_MULTI_LOAD: row = '{8, 8, 9, 0, 0, 3};
			ICTM_OP_MULTI_STORE: row = '{4, 4, 5, 0, 0, 3};
			ICTM_OP_PERIPH_W_TO_MEM: row = '{8, 11, 11, 0, 2, 0};
			ICTM_OP_PERIPH_L_TO_MEM: row = '{14, 17, 17, 0, 4, 0};
			ICTM_OP_PERIPH_W_TO_REG: row = '{10, 12, 12, 2, 0, 0};
			ICTM_OP_PERIPH_L_TO_REG: row = '{16, 18, 18, 4, 0, 0};
			ICTM_OP_ALT_TO_REG: row = '{7, 7, 8, 1, 0, 3};
			ICTM_OP_ALT_FROM_REG: row = '{5, 5, 7, 0, 1, 3};
			ICTM_OP_HALF_SWAP: row = '{1, 4, 4, 0, 0, 0};
			ICTM_OP_ALU_REG: row = '{0, 2, 3, 0, 0, 1};
			ICTM_OP_IMM_REG: row = '{0, 2, 3, 0, 0, 4};
			ICTM_OP_ALU_MEM, ICTM_OP_QUICK_MEM: row = '{3, 4, 6, 0, 1, 1};
			ICTM_OP_IMM_MEM: row = '{3, 4, 6, 0, 1, 4};
			ICTM_OP_ADDR_CMP: row = '{1, 4, 4, 0, 0, 1};
			ICTM_OP_BOUNDS_CMP: row = '{16, 18, 18, 1, 0, 4};
			ICTM_OP_MULT_W: row = '{25, 27, 28, 0, 0, 1};
			ICTM_OP_MULT_L: row = '{41, 43, 44, 0, 0, 4};
			ICTM_OP_UDIV_W: row = '{42, 44, 44, 0, 0, 1};
			ICTM_OP_UDIV_L: row = '{76, 78, 79, 0, 0, 4};
			ICTM_OP_SDIV_W: row = '{54, 56, 57, 0, 0, 1};
			ICTM_OP_SDIV_L: row = '{88, 90, 91, 0, 0, 4};
			default: row = '{0, 2, 3, 0, 0, 0};
		endcase
	endfunction : row
	// one run; poke raises start mid-run, which must be ignored
	task automatic run(input ictm_op_t op, input int col, input int n, input int add, input bit poke, output int nb);
		int k;
		@(posedge clk_i);
		#1;
		op_i = op;
		cache_hit_i = (col != 2);
		overlap_i = (col == 0);
		reg_count_i = 5'(n);
		addon_time_i = 8'(add);
		start_i = 1'b1;
		clr = 1'b1;
		@(posedge clk_i);
		#1;
		start_i = 1'b0;
		clr = 1'b0;
		nb = 0;
		k = 0;
		while (done_o !== 1'b1 && k < 400) begin
			if (busy_o === 1'b1) begin
				nb++;
			end
			start_i = poke && (k >= 3) && (k < 6);
			op_i = ICTM_OP_XCHG;
			@(posedge clk_i);
			#1;
			k++;
		end
		check("done wait", k < 400, 1);
		@(posedge clk_i);
		#1;
	endtask : run
	// run one form and judge totals, counts and bus traffic
	task automatic run_chk(input ictm_op_t op, input int col, input int n, input int add, input bit poke);
		ictm_row_t e;
		int t, nb, p, r, w;
		e = row(op);
		t = e[col] + (e[5] != 0 ? add : 0);
		r = (op == ICTM_OP_MULTI_LOAD) ? n : e[3];
		w = (op == ICTM_OP_MULTI_STORE) ? n : e[4];
		t += (op == ICTM_OP_MULTI_LOAD) ? 4 * n : (op == ICTM_OP_MULTI_STORE) ? 3 * n : 0;
		p = (col == 2) ? ((op == ICTM_OP_EA_TO_STAT) ? 2 : 1) : 0;
		run(op, col, n, add, poke, nb);
		check($sformatf("total op %0d col %0d", op, col), total_o, t);
		check("busy cycles", nb, t);
		check("reads", reads_o, r);
		check("writes", writes_o, w);
		check("prefetches", prefetches_o, p);
		check("bus reads", rd_n, r);
		check("bus writes", wr_n, w);
		check("bus prefetches", pf_n, p);
		check("column", column_o, col);
		check("add-on kind", addon_kind_o, e[5]);
	endtask : run_chk
	////////////////////////////////////////////////////////////////////////////////
	// values after reset
	task automatic sc_reset();
		check("reset ready", ready_o, 1);
		check("reset total", total_o, 0);
		check("reset column", column_o, 2);
		check("reset add-on", addon_kind_o, 0);
	endtask : sc_reset
	// every form in every column, with registers and add-on time
	task automatic sc_table();
		for (int i = 0; i <= ICTM_OP_IMM_MEM; i++) begin
			for (int c = 0; c < 3; c++) begin
				run_chk(ictm_op_t'(i), c, 3, 5, 1'b0);
			end
		end
	endtask : sc_table
	// register count and add-on at their limits
	task automatic sc_multi();
		run_chk(ICTM_OP_MULTI_LOAD, 2, 31, 255, 1'b0);
		run_chk(ICTM_OP_MULTI_STORE, 0, 0, 255, 1'b0);
		run_chk(ICTM_OP_MULTI_STORE, 2, 31, 0, 1'b0);
		run_chk(ICTM_OP_MULTI_LOAD, 1, 0, 0, 1'b0);
	endtask : sc_multi
	// a start during a long divide must not disturb it
	task automatic sc_refuse();
		run_chk(ICTM_OP_SDIV_L, 1, 0, 7, 1'b1);
		run_chk(ICTM_OP_UDIV_L, 2, 0, 0, 1'b1);
	endtask : sc_refuse
	// reset in mid-run, then a clean run
	task automatic sc_midreset();
		@(posedge clk_i);
		#1;
		op_i = ICTM_OP_MULT_L;
		cache_hit_i = 1'b0;
		start_i = 1'b1;
		@(posedge clk_i);
		#1;
		start_i = 1'b0;
		repeat (10) @(posedge clk_i);
		#1;
		rst_i = 1'b1;
		@(posedge clk_i);
		#1;
		rst_i = 1'b0;
		check("busy after reset", busy_o, 0);
		sc_reset();
		run_chk(ICTM_OP_MULT_L, 2, 0, 1, 1'b0);
	endtask : sc_midreset
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		sc_reset();
		sc_table();
		sc_multi();
		sc_refuse();
		sc_midreset();
		results();
	end
	// watchdog well beyond the roughly 3400 cycles the runs need
	initial begin
		repeat (40000) @(posedge clk_i);
		check("watchdog", 0, 1);
		results();
	end
endmodule : ictm_timing_tb

bind ictm_timing ictm_timing_sva u_ictm_timing_sva (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
	.cache_hit_i(cache_hit_i), .overlap_i(overlap_i), .reg_count_i(reg_count_i), .addon_time_i(addon_time_i),
	.ready_o(ready_o), .busy_o(busy_o), .done_o(done_o), .column_o(column_o), .addon_kind_o(addon_kind_o),
	.total_o(total_o), .reads_o(reads_o), .prefetches_o(prefetches_o), .writes_o(writes_o),
	.bus_read_o(bus_read_o), .bus_prefetch_o(bus_prefetch_o), .bus_write_o(bus_write_o));
